// ==== rtl/sacp_pkg.sv ====
// constants and state codes for the serial converter conversion port
// assumes a 10 MHz core clock; the shift clock is the link's own clock
// How it works
// - a rising convert strobe starts a conversion and floats the serial result output.
// - a conversion that ends with the strobe still high drops the core into sleep by itself.
// - a falling strobe drives the serial output and shows result bit 11 at once.
// - each later shift-clock falling edge moves the output on to the next bit.
// - once the result is out, every further shift-clock period gives a zero.
// - a frame is twelve result bits, msb first, then zeros, so sixteen clocks give four zeros.
// - while asleep the sample-and-hold keeps the last sampled input.
// - a falling strobe wakes the core and puts the sample-and-hold back to tracking.
// - a strobe left high after conversion makes the result readable only after its next fall.
// - conversion time comes from the core's own timer, never from the shift clock.
// - the result is straight binary, clamped to all ones above and all zeros below range.
package sacp_pkg;
   localparam int RESULT_BITS = 12;
   localparam int INPUT_BITS = 14;
   localparam int IDX_BITS = 5;
   localparam int CLK_PERIOD_NS = 100;
   // 100 ksps variant: conversion share of the sample period budget
   localparam int CONVERSION_INTERVAL_NS = 8000;
   localparam int ACQUISITION_INTERVAL_NS = 500;
   localparam int CONVERT_CYCLES = (CONVERSION_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACQ_CYCLES = (ACQUISITION_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_BITS = 8;
   localparam logic [CNT_BITS-1:0] CONVERT_LAST = CNT_BITS'(CONVERT_CYCLES - 1);
   localparam logic [CNT_BITS-1:0] ACQ_LAST = CNT_BITS'(ACQ_CYCLES - 1);
   localparam logic [CNT_BITS-1:0] CNT_ZERO = 8'h00;
   localparam logic [IDX_BITS-1:0] IDX_END = 5'h0C;
   localparam logic [IDX_BITS-1:0] IDX_ZERO = 5'h00;
   localparam logic [RESULT_BITS-1:0] RESULT_ALL_ONES = 12'hFFF;
   localparam logic [RESULT_BITS-1:0] RESULT_ZERO = 12'h000;
   localparam logic [INPUT_BITS-1:0] INPUT_FULL = 14'h0FFF;
   localparam logic [INPUT_BITS-1:0] INPUT_ZERO = 14'h0000;
   typedef enum logic [2:0] {
      SACP_TRACK = 3'b001,
      SACP_CONVERT = 3'b010,
      SACP_SLEEP = 3'b100
   } sacp_state_t;
endpackage

// ==== rtl/sacp_sync2.sv ====
// two-flop level synchroniser, any width
// assumes each bit is a level that stays put across several destination clocks
`timescale 1ns/1ns
`default_nettype none
module sacp_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         sync_o <= '0;
      end else begin
         meta_reg <= async_i;
         sync_o <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/sacp_port.sv ====
// conversion control and three-wire serial readout of a 12-bit sampling converter
// assumes the host drives the strobe and shift clock and samples the output on rising edges
`timescale 1ns/1ns
`default_nettype none
module sacp_port (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic shift_clk_i,
   input wire logic convert_strobe_i,
   input wire logic [sacp_pkg::INPUT_BITS-1:0] analog_level_i,
   output logic serial_result_out_o,
   output logic serial_result_oe_n_o,
   output logic converting_o,
   output logic sleeping_o,
   output logic tracking_o,
   output logic acquired_o,
   output logic early_fall_o,
   output logic [sacp_pkg::RESULT_BITS-1:0] result_o
);
   import sacp_pkg::*;

   // core domain
   logic strobe_sync;
   logic strobe_d_reg;
   logic [INPUT_BITS-1:0] level_sync;
   sacp_state_t state_reg;
   sacp_state_t state_next;
   logic [CNT_BITS-1:0] convert_cnt_reg;
   logic [CNT_BITS-1:0] acq_cnt_reg;
   logic [INPUT_BITS-1:0] held_reg;
   logic [RESULT_BITS-1:0] result_reg;
   logic early_reg;
   logic acq_reg;

   sacp_sync2 #(.WIDTH(1)) u_strobe_sync (
      .clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i(convert_strobe_i),
      .sync_o(strobe_sync)
   );

   // level input is a slow analog stand-in; bitwise sync is enough here
   sacp_sync2 #(.WIDTH(INPUT_BITS)) u_level_sync (
      .clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i(analog_level_i),
      .sync_o(level_sync)
   );

   wire strobe_rise = strobe_sync & ~strobe_d_reg;
   wire strobe_fall = ~strobe_sync & strobe_d_reg;
   wire convert_done = (state_reg == SACP_CONVERT) && (convert_cnt_reg == CONVERT_LAST);
   wire level_neg = held_reg[INPUT_BITS-1];
   wire level_over = !level_neg && (held_reg > INPUT_FULL);
   wire [RESULT_BITS-1:0] clamped = level_neg ? RESULT_ZERO :
      (level_over ? RESULT_ALL_ONES : held_reg[RESULT_BITS-1:0]);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SACP_TRACK: begin
            if (strobe_rise) begin
               state_next = SACP_CONVERT;
            end
         end
         SACP_CONVERT: begin
            if (strobe_fall) begin
               state_next = SACP_TRACK;
            end else if (convert_done) begin
               state_next = strobe_sync ? SACP_SLEEP : SACP_TRACK;
            end
         end
         SACP_SLEEP: begin
            if (strobe_fall) begin
               state_next = SACP_TRACK;
            end
         end
         default: begin
            state_next = SACP_TRACK;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_reg <= SACP_TRACK;
         strobe_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         strobe_d_reg <= strobe_sync;
      end
   end

   // own timer sets conversion length, shift clock plays no part
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || state_reg != SACP_CONVERT) begin
         convert_cnt_reg <= CNT_ZERO;
      end else if (!convert_done) begin
         convert_cnt_reg <= convert_cnt_reg + 8'h01;
      end
   end

   // held value freezes from the rising strobe until tracking resumes
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         held_reg <= INPUT_ZERO;
      end else if (state_reg == SACP_TRACK && !strobe_rise) begin
         held_reg <= level_sync;
      end
   end

   // result only moves on a full conversion, never partially
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         result_reg <= RESULT_ZERO;
      end else if (convert_done && !strobe_fall) begin
         result_reg <= clamped;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         early_reg <= 1'b0;
      end else if (state_reg == SACP_CONVERT && strobe_fall) begin
         early_reg <= 1'b1;
      end else if (strobe_rise) begin
         early_reg <= 1'b0;
      end
   end

   // tells the host side that a new rise is now safe
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || state_reg != SACP_TRACK) begin
         acq_cnt_reg <= CNT_ZERO;
         acq_reg <= 1'b0;
      end else if (acq_cnt_reg == ACQ_LAST) begin
         acq_reg <= 1'b1;
      end else begin
         acq_cnt_reg <= acq_cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         converting_o <= 1'b0;
         sleeping_o <= 1'b0;
         tracking_o <= 1'b1;
         acquired_o <= 1'b0;
         early_fall_o <= 1'b0;
         result_o <= RESULT_ZERO;
      end else begin
         converting_o <= (state_next == SACP_CONVERT);
         sleeping_o <= (state_next == SACP_SLEEP);
         tracking_o <= (state_next == SACP_TRACK);
         acquired_o <= acq_reg;
         early_fall_o <= early_reg;
         result_o <= result_reg;
      end
   end

   // link domain: bit index on the shift clock's falling edge.
   // the strobe itself clears it, so msb shows with no shift edge needed.
   // result_reg is quasi-static here: it only changes while the strobe is high.
   logic [IDX_BITS-1:0] idx_reg;

   always_ff @(negedge shift_clk_i or posedge convert_strobe_i) begin
      if (convert_strobe_i) begin
         idx_reg <= IDX_ZERO;
      end else if (idx_reg != IDX_END) begin
         idx_reg <= idx_reg + 5'h01;
      end
   end

   wire [3:0] bit_sel = 4'(RESULT_BITS - 1) - idx_reg[3:0];
   wire data_bit = (idx_reg == IDX_END) ? 1'b0 : result_reg[bit_sel];

   // pin-level path: combinational so the msb and float follow the strobe edge
   assign serial_result_out_o = data_bit;
   assign serial_result_oe_n_o = convert_strobe_i;
endmodule
`default_nettype wire

// ==== test/sacp_port_sva.sv ====
// pin-level assertions for the conversion port
// assumes one core clock domain, bound to sacp_port
`timescale 1ns/1ns
`default_nettype none
module sacp_port_sva (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic convert_strobe_i,
   input wire logic serial_result_out_o,
   input wire logic serial_result_oe_n_o,
   input wire logic converting_o,
   input wire logic sleeping_o,
   input wire logic tracking_o,
   input wire logic early_fall_o,
   input wire logic [sacp_pkg::RESULT_BITS-1:0] result_o
);
   import sacp_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // counts conversion cycles; 8 bits covers the 80 needed
   logic [7:0] len_reg;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !converting_o) len_reg <= 8'h00;
      else len_reg <= len_reg + 8'h01;
   end
   sequence s_wake;
      ##[2:5] tracking_o && !sleeping_o;
   endsequence
   property p_float; serial_result_oe_n_o == convert_strobe_i; endproperty
   property p_start; $rose(convert_strobe_i) |-> ##[2:5] converting_o && !tracking_o; endproperty
   // a cut conversion ends without sleep; only full ones are timed
   property p_len; $fell(converting_o) && sleeping_o |-> len_reg == CONVERT_LAST + 8'h01; endproperty
   property p_early; $fell(converting_o) && !sleeping_o |-> ##1 early_fall_o; endproperty
   property p_sleep; $fell(converting_o) && convert_strobe_i |-> ##[0:1] sleeping_o; endproperty
   property p_late; $changed(result_o) |-> sleeping_o; endproperty
   property p_keep; sleeping_o && $past(sleeping_o, 2) |-> $stable(result_o); endproperty
   property p_wake; $fell(convert_strobe_i) |-> s_wake; endproperty
   property p_msb; $fell(convert_strobe_i) |-> serial_result_out_o == result_o[11]; endproperty
   a_float: assert property (p_float) else $error("output driven while strobe high");
   a_start: assert property (p_start) else $error("no conversion after rise");
   a_len: assert property (p_len) else $error("conversion length wrong");
   a_early: assert property (p_early) else $error("cut conversion not flagged");
   a_sleep: assert property (p_sleep) else $error("no sleep after conversion");
   a_late: assert property (p_late) else $error("result moved outside sleep");
   a_keep: assert property (p_keep) else $error("held sample changed");
   a_wake: assert property (p_wake) else $error("no tracking after fall");
   a_msb: assert property (p_msb) else $error("top bit not shown");
endmodule
bind sacp_port sacp_port_sva u_sva (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .convert_strobe_i(convert_strobe_i), .serial_result_out_o(serial_result_out_o),
   .serial_result_oe_n_o(serial_result_oe_n_o), .converting_o(converting_o),
   .sleeping_o(sleeping_o), .tracking_o(tracking_o), .early_fall_o(early_fall_o),
   .result_o(result_o));
`default_nettype wire

// ==== test/sacp_host.sv ====
// host model: drives strobe and 64 ns shift clock, samples on rising edges
// assumes the core clock paces the strobe
`timescale 1ns/1ns
`default_nettype none
module sacp_host (
   input wire logic ref_clk_i,
   input wire logic serial_result_out_i,
   output logic shift_clk_o,
   output logic convert_strobe_o
);
   initial begin
      shift_clk_o = 1'b0;
      convert_strobe_o = 1'b0;
   end
   // shift clock idles low, untouched while converting
   task automatic start_convert(input int hold);
      @(posedge ref_clk_i);
      convert_strobe_o <= 1'b1;
      repeat (hold) @(posedge ref_clk_i);
   endtask
   task automatic read_frame(input int n, output logic [31:0] bits);
      bits = 32'h0;
      convert_strobe_o <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      #13;
      for (int i = 0; i < n; i++) begin
         #32 shift_clk_o = 1'b1;
         bits = {bits[30:0], serial_result_out_i};
         #32 shift_clk_o = 1'b0;
      end
      // acquisition wait plus sync slack before any new rise
      repeat (7) @(posedge ref_clk_i);
   endtask
endmodule
`default_nettype wire

// ==== test/sacp_port_tb.sv ====
// self-checking bench for the conversion port
// assumes sacp_host drives strobe and shift clock
`timescale 1ns/1ns
`default_nettype none
module sacp_port_tb;
   import sacp_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [INPUT_BITS-1:0] lvl = 14'h0000;
   wire logic sck, strobe, ser_out, oe_n, sleep, track, early, acq;
   wire logic [RESULT_BITS-1:0] result;
   int bad_count = 0;
   int compares = 0;
   always #50 ref_clk_i = ~ref_clk_i;
   sacp_port u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .shift_clk_i(sck),
      .convert_strobe_i(strobe), .analog_level_i(lvl), .serial_result_out_o(ser_out),
      .serial_result_oe_n_o(oe_n), .converting_o(), .sleeping_o(sleep),
      .tracking_o(track), .acquired_o(acq), .early_fall_o(early), .result_o(result));
   sacp_host u_host (.ref_clk_i(ref_clk_i), .serial_result_out_i(ser_out),
      .shift_clk_o(sck), .convert_strobe_o(strobe));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %0t %s", $time, what);
      end
   endtask
   task automatic tally_and_finish();
      if (bad_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // out-of-range inputs clamp to the rails
   function automatic logic [11:0] clamp(input logic [13:0] v);
      if (v[13]) return 12'h000;
      if (v > 14'h0FFF) return 12'hFFF;
      return v[11:0];
   endfunction
   // input flips once the sample is held, so the result must keep the held value
   task automatic run(input logic [13:0] v, input int hold, input int n, output logic [31:0] b);
      @(posedge ref_clk_i);
      lvl <= v;
      repeat (6) @(posedge ref_clk_i);
      u_host.start_convert(8);
      lvl <= ~v;
      repeat (hold - 8) @(posedge ref_clk_i);
      check({31'h0, sleep}, 32'h1, "not asleep");
      check({31'h0, oe_n}, 32'h1, "output driven");
      check({31'h0, acq}, 32'h0, "acquired while asleep");
      u_host.read_frame(n, b);
      check({31'h0, track}, 32'h1, "not tracking");
      check({31'h0, oe_n}, 32'h0, "output not driven");
      check({31'h0, acq}, 32'h1, "acquisition not flagged");
   endtask
   task automatic t_codes();
      logic [13:0] lv[5] = '{14'h0ABC, 14'h0000, 14'h0FFF, 14'h1234, 14'h3FF0};
      logic [31:0] b;
      foreach (lv[i]) begin
         run(lv[i], 100, 16, b);
         check(b, {16'h0, clamp(lv[i]), 4'h0}, "frame");
         check({20'h0, result}, {20'h0, clamp(lv[i])}, "result");
      end
   endtask
   task automatic t_quick();
      logic [31:0] b;
      run(14'h0555, 88, 24, b);
      check(b, {8'h0, 12'h555, 12'h000}, "tail");
   endtask
   // strobe dropped mid-conversion: flagged, old result kept, flag gone on next rise
   task automatic t_early();
      logic [31:0] b;
      u_host.start_convert(20);
      u_host.read_frame(12, b);
      check({31'h0, early}, 32'h1, "no early flag");
      check(b, 32'h0000_0555, "partial frame");
      check({20'h0, result}, 32'h0000_0555, "partial result");
      run(14'h0ABC, 100, 16, b);
      check({31'h0, early}, 32'h0, "early flag stuck");
      check(b, 32'h0000_ABC0, "frame after early");
   endtask
   initial begin
      #1_000_000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      check({31'h0, track}, 32'h1, "reset state");
      t_codes();
      t_quick();
      t_early();
      tally_and_finish();
   end
endmodule
`default_nettype wire
